// ==== aal2_rx_pkg.sv ====
package aal2_rx_pkg;
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_SAMPLES = 12'h004;
  localparam logic [11:0] ADDR_MAX_USED = 12'h008;
  localparam logic [11:0] ADDR_LEADS = 12'h00C;
  localparam logic [11:0] ADDR_OVR_CH = 12'h010;
  localparam logic [11:0] ADDR_MIN_DELTA = 12'h014;
  localparam logic [11:0] ADDR_MAX_DELTA = 12'h018;
  localparam logic [11:0] ADDR_REMOTE_TS = 12'h01C;
  localparam logic [11:0] ADDR_PKT_COUNT = 12'h020;
  localparam logic [11:0] ADDR_OCT_COUNT = 12'h024;
  localparam logic [11:0] ADDR_CTX_ADDR = 12'h028;
  localparam logic [11:0] ADDR_WRITE_POS = 12'h02C;
  localparam logic [1:0] BASE_TAB_PAGE = 2'h1;
  localparam logic [7:0] BASE_TAB_LEN = 8'hFF;
  localparam int CTRL_RESTART = 0;
  localparam int CTRL_INIT = 1;
  localparam int CTRL_LOSS_EN = 2;
  localparam int CTRL_SLIP_EN = 3;
  localparam int CTRL_INIT_RPT = 4;
  localparam int CTRL_SIZE_LSB = 5;
  localparam int CTRL_SHARED_INIT = 8;
  localparam int HI_LSB = 16;
  localparam logic [2:0] SIZE_SEL_MAX = 3'h4;
  localparam logic [12:0] SIZE_UNIT = 13'h0100;
  localparam logic [7:0] OCTET_EXTRA = 8'h04;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {ST_IDLE, ST_CALC, ST_UPDATE, ST_REPORT} rx_state_e;

  typedef struct packed {
    logic [3:0] seq;
    logic [7:0] li;
    logic [11:0] samples;
  } rx_pkt_s;

  typedef struct packed {
    logic [15:0] base;
    logic [11:0] offset;
    logic [11:0] count;
  } buf_write_s;

  typedef struct packed {
    logic underrun2;
    logic underrun;
    logic overrun;
    logic chan_init;
    logic shared_pdv_initialized;
    logic restart_done;
    logic samples_lost_flag;
    logic length_not_divisible_error;
    logic length_oversize_error;
    logic [31:0] samples_lost;
    logic [31:0] ctx_addr;
    logic [31:0] remote_ts;
    logic [31:0] local_ts;
  } rx_report_s;
endpackage

// ==== aal2_voice_rx_dejitter_channel.sv ====
// Added by the designer: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// RL1 - Software sets restart bit; next packet restarts monitoring and hardware clears it.
// RL2 - On restart, minimum and maximum delta both load the first packet's delta.
// RL3 - Software clears initialized bit at setup; first received packet sets it.
// RL4 - Sample count of the latest packet is stored; software zeroes it at init.
// RL5 - Software programs largest expected samples per packet, zero when unknown.
// RL6 - Maximum used samples bounds buffered samples; zero accepts single-sample packets only.
// RL7 - First sample of first packet lands at initial lead frames past playout.
// RL8 - Underrun packets start at the underrun lead position.
// RL9 - Overrun packets start at the overrun lead position.
// RL10 - Track minimum and maximum of local minus rebuilt remote timestamp.
// RL11 - Save rebuilt remote timestamp of the latest packet.
// RL12 - Count every packet reaching the channel, whatever its outcome.
// RL13 - Add length indicator plus four to the octet counter per packet.
// RL14 - Per-channel buffer base in 256-byte units, up to 255 entries.
// RL15 - Underrun, second underrun and overrun are flagged in event reports.
// RL16 - Flag error when sample count is not a multiple of channel count.
// RL17 - Flag error when packet does not fit the circular buffer.
// RL18 - Lost samples set a flag and a 32-bit count in the report.
// RL19 - First initialization of channel and shared context can be reported.
// RL20 - Reports carry context address, local timestamp and remote timestamp.
// RL21 - Size code picks 256 to 4096 byte buffer; other codes reserved.
// RL22 - Loss compensation places by sequence number, otherwise back to back.
// RL23 - Slip reporting enabled emits a report for each underrun or overrun.
// RL24 - Software keeps channel count between one and 255.
// RL25 - All updates for one packet finish before the next packet is taken.
module aal2_voice_rx_dejitter_channel
  import aal2_rx_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire rx_pkt_s pkt,
  input wire logic pkt_valid,
  output logic pkt_ready,
  input wire logic [31:0] local_ts,
  input wire logic [11:0] play_pos,
  output buf_write_s buf_write,
  output logic buf_write_valid,
  output rx_report_s report,
  output logic report_valid,
  input wire logic report_ready
);
  rx_state_e state;
  logic [31:0] ctrl;
  logic [11:0] last_samples, max_expected, max_used, init_lead, underrun_lead, overrun_lead;
  logic [7:0] num_channels;
  logic [31:0] min_delta, max_delta, last_remote, pkt_count, oct_count, ctx_addr;
  logic [11:0] write_pos;
  logic [3:0] last_seq;
  logic [15:0] base_tab [255];
  rx_pkt_s cur;
  logic [31:0] r_remote, r_lost, r_delta;
  logic r_first;
  logic aw_got, w_got;
  logic [11:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // Write path: address and data may arrive in either order
  wire logic do_write = aw_got && w_got && !s_axi_bvalid;
  wire logic tab_sel_w = (aw_addr[11:10] == BASE_TAB_PAGE) && (aw_addr[9:2] < BASE_TAB_LEN);
  wire logic [7:0] tab_idx_w = aw_addr[9:2];
  logic w_hit;
  logic [31:0] w_old;
  logic [31:0] w_new;

  // Old word of the target, so unstrobed bytes are kept
  always_comb begin
    w_hit = 1'b1;
    case (aw_addr)
      ADDR_CTRL: w_old = ctrl;
      ADDR_SAMPLES: w_old = {4'h0, max_expected, 4'h0, last_samples};
      ADDR_MAX_USED: w_old = {20'h00000, max_used};
      ADDR_LEADS: w_old = {4'h0, underrun_lead, 4'h0, init_lead};
      ADDR_OVR_CH: w_old = {8'h00, num_channels, 4'h0, overrun_lead};
      ADDR_PKT_COUNT: w_old = pkt_count;
      ADDR_OCT_COUNT: w_old = oct_count;
      ADDR_CTX_ADDR: w_old = ctx_addr;
      default: begin
        w_hit = tab_sel_w;
        w_old = tab_sel_w ? {16'h0000, base_tab[tab_idx_w]} : 32'h0000_0000;
      end
    endcase
    w_new = merge(w_old, w_data, w_strb);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_addr <= 12'h000;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_got && !(s_axi_awvalid && s_axi_awready) && !do_write;
      s_axi_wready <= !w_got && !(s_axi_wvalid && s_axi_wready) && !do_write;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got <= 1'b1;
        aw_addr <= {s_axi_awaddr[11:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_got <= 1'b0;
        w_got <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= w_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (do_write && tab_sel_w) begin
      base_tab[tab_idx_w] <= w_new[15:0]; // RL14
    end
  end

  // Read path
  wire logic tab_sel_r = (s_axi_araddr[11:10] == BASE_TAB_PAGE) && (s_axi_araddr[9:2] < BASE_TAB_LEN);
  logic [31:0] rd_data;
  logic rd_hit;

  always_comb begin
    rd_hit = 1'b1;
    rd_data = 32'h0000_0000;
    case ({s_axi_araddr[11:2], 2'b00})
      ADDR_CTRL: rd_data = ctrl;
      ADDR_SAMPLES: rd_data = {4'h0, max_expected, 4'h0, last_samples};
      ADDR_MAX_USED: rd_data = {20'h00000, max_used};
      ADDR_LEADS: rd_data = {4'h0, underrun_lead, 4'h0, init_lead};
      ADDR_OVR_CH: rd_data = {8'h00, num_channels, 4'h0, overrun_lead};
      ADDR_MIN_DELTA: rd_data = min_delta;
      ADDR_MAX_DELTA: rd_data = max_delta;
      ADDR_REMOTE_TS: rd_data = last_remote;
      ADDR_PKT_COUNT: rd_data = pkt_count;
      ADDR_OCT_COUNT: rd_data = oct_count;
      ADDR_CTX_ADDR: rd_data = ctx_addr;
      ADDR_WRITE_POS: rd_data = {20'h00000, write_pos};
      default: begin
        rd_hit = tab_sel_r;
        rd_data = tab_sel_r ? {16'h0000, base_tab[s_axi_araddr[9:2]]} : 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_data;
        s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Remote timestamp rebuilt from the 4-bit sequence number
  wire logic [3:0] seq_step = cur.seq - last_seq;
  wire logic first_pkt = !ctrl[CTRL_INIT];
  wire logic [31:0] step_ts = 32'(seq_step) * 32'(last_samples);
  wire logic [31:0] step_lost = 32'(seq_step - 4'h1) * 32'(last_samples);
  wire logic [31:0] remote_n = first_pkt ? local_ts : last_remote + step_ts; // RL11

  // Placement, evaluated in ST_UPDATE
  wire logic [2:0] sel = (ctrl[CTRL_SIZE_LSB +: 3] > SIZE_SEL_MAX) ? SIZE_SEL_MAX
                                                                   : ctrl[CTRL_SIZE_LSB +: 3];
  wire logic [12:0] buf_size = SIZE_UNIT << sel; // RL21
  wire logic [11:0] mask = 12'(buf_size - 13'h0001);
  // Channel count of zero is outside the legal range and is treated as a bad length
  wire logic bad_div = (num_channels == 8'h00) || ((cur.samples % 12'(num_channels)) != 12'h000); // RL16
  wire logic oversize = {1'b0, cur.samples} > buf_size; // RL17
  wire logic len_err = bad_div || oversize;
  wire logic [11:0] exp_pos = (ctrl[CTRL_LOSS_EN] ? write_pos + r_lost[11:0] : write_pos) & mask; // RL22
  wire logic [11:0] lead = (exp_pos - play_pos) & mask;
  wire logic behind = lead > (mask >> 1);
  wire logic [11:0] pkt_lag = (max_expected > cur.samples) ? max_expected - cur.samples : 12'h000; // RL5
  wire logic u2 = !r_first && behind;
  wire logic u1 = !r_first && (behind || lead < pkt_lag);
  // Thirteen bits so a long packet cannot wrap past the limit
  wire logic [12:0] last_lead = {1'b0, lead} + {1'b0, cur.samples} - 13'h0001;
  wire logic ov = !r_first && !u1 && (last_lead > {1'b0, max_used}); // RL6
  logic [11:0] start;

  always_comb begin
    if (r_first) begin
      start = (play_pos + init_lead) & mask; // RL7
    end else if (u1) begin
      start = (play_pos + underrun_lead) & mask; // RL8
    end else if (ov) begin
      start = (play_pos + overrun_lead) & mask; // RL9
    end else begin
      start = exp_pos;
    end
  end

  wire logic sw_ctrl = do_write && aw_addr == ADDR_CTRL;
  wire logic upd = state == ST_UPDATE;
  wire logic [31:0] ctrl_sw = sw_ctrl ? w_new : ctrl;
  wire logic want_rpt = len_err || r_lost != 32'h0000_0000 || u2
                      || (ctrl[CTRL_SLIP_EN] && (u1 || ov))
                      || (ctrl[CTRL_INIT_RPT] && (r_first || !ctrl[CTRL_SHARED_INIT]));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= CTRL_RESET;
    end else begin
      ctrl <= ctrl_sw;
      // A fresh software request in the same cycle survives the hardware clear
      if (upd && !(sw_ctrl && w_strb[0] && w_data[CTRL_RESTART])) begin
        ctrl[CTRL_RESTART] <= 1'b0; // RL1
      end
      if (upd) begin
        ctrl[CTRL_INIT] <= 1'b1; // RL3
        ctrl[CTRL_SHARED_INIT] <= 1'b1; // RL19
      end
    end
  end

  // Context fields; hardware updates override a same-cycle software write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {last_samples, max_expected, max_used} <= '0;
      {init_lead, underrun_lead, overrun_lead, num_channels} <= '0;
      {min_delta, max_delta, last_remote} <= '0;
      {pkt_count, oct_count, ctx_addr} <= '0;
      write_pos <= 12'h000;
      last_seq <= 4'h0;
    end else begin
      if (do_write) begin
        case (aw_addr)
          ADDR_SAMPLES: {max_expected, last_samples} <= {w_new[27:16], w_new[11:0]}; // RL4
          ADDR_MAX_USED: max_used <= w_new[11:0];
          ADDR_LEADS: {underrun_lead, init_lead} <= {w_new[27:16], w_new[11:0]};
          ADDR_OVR_CH: {num_channels, overrun_lead} <= {w_new[23:16], w_new[11:0]}; // RL24
          ADDR_PKT_COUNT: pkt_count <= w_new;
          ADDR_OCT_COUNT: oct_count <= w_new;
          ADDR_CTX_ADDR: ctx_addr <= w_new;
          default: ;
        endcase
      end
      if (upd) begin
        pkt_count <= pkt_count + 32'h0000_0001; // RL12
        oct_count <= oct_count + 32'(cur.li) + 32'(OCTET_EXTRA); // RL13
        last_samples <= cur.samples; // RL4
        last_seq <= cur.seq;
        last_remote <= r_remote; // RL11
        if (r_first || ctrl[CTRL_RESTART]) begin
          min_delta <= r_delta; // RL2
          max_delta <= r_delta; // RL2
        end else begin
          if ($signed(r_delta) < $signed(min_delta)) min_delta <= r_delta; // RL10
          if ($signed(r_delta) > $signed(max_delta)) max_delta <= r_delta; // RL10
        end
        // Bad lengths are discarded, so the pointer stays put
        if (!len_err) begin
          write_pos <= (start + cur.samples) & mask;
        end
      end
    end
  end

  // Packet sequencer: one packet is fully retired before the next is accepted
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= ST_IDLE;
      pkt_ready <= 1'b0;
      cur <= '0;
      {r_remote, r_lost, r_delta} <= '0;
      r_first <= 1'b0;
      buf_write_valid <= 1'b0;
      buf_write <= '0;
      report_valid <= 1'b0;
      report <= '0;
    end else begin
      buf_write_valid <= 1'b0;
      case (state)
        ST_IDLE: begin
          pkt_ready <= !(pkt_valid && pkt_ready);
          if (pkt_valid && pkt_ready) begin
            cur <= pkt;
            state <= ST_CALC; // RL25
          end
        end
        ST_CALC: begin
          r_first <= first_pkt;
          r_remote <= remote_n;
          r_delta <= local_ts - remote_n; // RL10
          r_lost <= (ctrl[CTRL_LOSS_EN] && !first_pkt && seq_step > 4'h1) ? step_lost
                                                                          : 32'h0000_0000;
          state <= ST_UPDATE;
        end
        ST_UPDATE: begin
          buf_write_valid <= !len_err;
          buf_write <= '{base: base_tab[0], offset: start, count: cur.samples}; // RL14
          report <= '{underrun2: u2, underrun: u1, overrun: ov, // RL15
                      chan_init: r_first, shared_pdv_initialized: !ctrl[CTRL_SHARED_INIT], // RL19
                      restart_done: ctrl[CTRL_RESTART],
                      samples_lost_flag: r_lost != 32'h0000_0000, samples_lost: r_lost, // RL18
                      length_not_divisible_error: bad_div, length_oversize_error: oversize,
                      ctx_addr: ctx_addr, remote_ts: r_remote, local_ts: local_ts}; // RL20
          if (want_rpt) begin
            report_valid <= 1'b1; // RL23
            state <= ST_REPORT;
          end else begin
            pkt_ready <= 1'b1;
            state <= ST_IDLE;
          end
        end
        ST_REPORT: begin
          // Reports are never dropped; a stalled queue stalls packet intake
          if (report_ready) begin
            report_valid <= 1'b0;
            pkt_ready <= 1'b1;
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// ==== aal2_rx_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
module aal2_rx_asserts
  import aal2_rx_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire rx_pkt_s pkt,
  input wire logic pkt_valid,
  input wire logic pkt_ready,
  input wire buf_write_s buf_write,
  input wire logic buf_write_valid,
  input wire rx_report_s report,
  input wire logic report_valid,
  input wire logic report_ready
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_wr_answer;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid;
  endproperty
  a_wr_answer: assert property (p_wr_answer) else $error("write answer missing");
  property p_rd_answer;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read answer missing");
  property p_rd_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data dropped");
  // Busy window keeps one packet's updates apart from the next
  property p_pkt_busy;
    pkt_valid && pkt_ready |=> !pkt_ready [*2];
  endproperty
  a_pkt_busy: assert property (p_pkt_busy) else $error("packet taken while busy");
  property p_bw_cause;
    buf_write_valid |-> $past(pkt_valid && pkt_ready, 3);
  endproperty
  a_bw_cause: assert property (p_bw_cause) else $error("write without packet");
  property p_bw_pulse;
    buf_write_valid |=> !buf_write_valid;
  endproperty
  a_bw_pulse: assert property (p_bw_pulse) else $error("write pulse too long");
  property p_bw_count;
    buf_write_valid |-> buf_write.count == $past(pkt.samples, 3);
  endproperty
  a_bw_count: assert property (p_bw_count) else $error("write count wrong");
  property p_rep_cause;
    $rose(report_valid) |-> $past(pkt_valid && pkt_ready, 3);
  endproperty
  a_rep_cause: assert property (p_rep_cause) else $error("report without packet");
  property p_rep_hold;
    report_valid && !report_ready |=> report_valid && $stable(report);
  endproperty
  a_rep_hold: assert property (p_rep_hold) else $error("report changed while held");
endmodule
`default_nettype wire

// ==== aal2_rx_partner.sv ====
`timescale 1ns/1ps
`default_nettype none
module aal2_rx_partner
  import aal2_rx_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic pkt_ready,
  input wire buf_write_s buf_write,
  input wire logic buf_write_valid,
  input wire rx_report_s report,
  input wire logic report_valid,
  output rx_pkt_s pkt,
  output logic pkt_valid,
  output logic [31:0] local_ts,
  output logic [11:0] play_pos,
  output logic report_ready
);
  int rpt_wait = 0;
  int wait_cnt = 0;
  int bw_cnt = 0, rep_cnt = 0;
  buf_write_s bw_last;
  rx_report_s rep_last;
  initial begin
    pkt <= '0;
    pkt_valid <= 1'h0;
    local_ts <= 32'h0;
    play_pos <= 12'h0;
  end
  task automatic send(input logic [3:0] sq, input logic [11:0] n, input logic [31:0] ts,
                      input logic [11:0] pos);
    @(posedge aclk);
    pkt <= '{sq, 8'h2B, n};
    pkt_valid <= 1'h1;
    local_ts <= ts;
    play_pos <= pos;
    do @(posedge aclk); while (!pkt_ready);
    pkt_valid <= 1'h0;
    // Released payload flips so a stale value is never mistaken for a hold
    pkt <= ~pkt;
  endtask
  // Report sink can stall for rpt_wait plus one cycles, like a full queue
  always @(posedge aclk) begin
    if (!aresetn) begin
      report_ready <= 1'h0;
      wait_cnt <= 0;
    end else begin
      wait_cnt <= (report_valid && !report_ready) ? wait_cnt + 1 : 0;
      report_ready <= report_valid && !report_ready && wait_cnt >= rpt_wait;
    end
    if (buf_write_valid) begin
      bw_cnt <= bw_cnt + 1;
      bw_last <= buf_write;
    end
    if (report_valid && report_ready) begin
      rep_cnt <= rep_cnt + 1;
      rep_last <= report;
    end
  end
endmodule
`default_nettype wire

// ==== tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb
  import aal2_rx_pkg::*;
;
  localparam logic [31:0] ALL = 32'hFFFF_FFFF;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic pkt_valid, pkt_ready, buf_write_valid, report_valid, report_ready;
  logic [11:0] s_axi_awaddr, s_axi_araddr, play_pos;
  logic [31:0] s_axi_wdata, s_axi_rdata, local_ts;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  rx_pkt_s pkt;
  buf_write_s buf_write;
  rx_report_s report;
  int n_errors = 0;
  int total_checks = 0;
  aal2_voice_rx_dejitter_channel u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0),
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .pkt, .pkt_valid, .pkt_ready, .local_ts, .play_pos,
    .buf_write, .buf_write_valid, .report, .report_valid, .report_ready);
  aal2_rx_partner u_far (.aclk, .aresetn, .pkt_ready, .buf_write, .buf_write_valid, .report,
    .report_valid, .pkt, .pkt_valid, .local_ts, .play_pos, .report_ready);
  initial begin
    aclk = 1'h0;
    forever #12.5 aclk = ~aclk;
  end
  task automatic final_report;
    $display("errors %0d checks %0d", n_errors, total_checks);
    if (n_errors == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    int k;
    k = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge aclk);
      k++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid && k < 100);
    s_axi_bready <= 1'h0;
    chk({30'h0, s_axi_bresp}, {30'h0, er});
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e,
                       input logic [1:0] er);
    int k;
    k = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge aclk);
      k++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid && k < 100);
    s_axi_rready <= 1'h0;
    chk({30'h0, s_axi_rresp}, {30'h0, er});
    if (er == RESP_OKAY) chk(s_axi_rdata & m, e);
  endtask
  // Offset ALL means the packet must not reach the buffer
  task automatic pkt_go(input logic [3:0] sq, input logic [11:0] n, input logic [31:0] ts,
                        input logic [11:0] pos, input logic [31:0] off, input logic [31:0] rpt);
    int b0, r0, k;
    b0 = u_far.bw_cnt;
    r0 = u_far.rep_cnt;
    k = 0;
    u_far.send(sq, n, ts, pos);
    do begin
      @(posedge aclk);
      k++;
    end while (!pkt_ready && k < 60);
    @(posedge aclk);
    chk(u_far.rep_cnt - r0, rpt);
    chk(u_far.bw_cnt - b0, (off === ALL) ? 32'h0 : 32'h1);
    if (off !== ALL) chk({20'h0, u_far.bw_last.offset}, off);
  endtask
  task automatic t_regs;
    rdchk(ADDR_CTRL, ALL, CTRL_RESET, RESP_OKAY);
    rdchk(ADDR_PKT_COUNT, ALL, 32'h0, RESP_OKAY);
    rdchk(12'h300, ALL, 32'h0, RESP_SLVERR);
    wr(12'h300, 32'h5, RESP_SLVERR);
    wr(12'h7FC, 32'h5, RESP_SLVERR);
    wr(ADDR_SAMPLES, 32'h0028_0000, RESP_OKAY);
    wr(ADDR_MAX_USED, 32'hC8, RESP_OKAY);
    wr(ADDR_LEADS, 32'h0008_0005, RESP_OKAY);
    wr(ADDR_OVR_CH, 32'h0001_0003, RESP_OKAY);
    wr(12'h400, 32'h12, RESP_OKAY);
    wr(ADDR_CTX_ADDR, 32'hABCD_0000, RESP_OKAY);
    wr(ADDR_MIN_DELTA, 32'h5, RESP_SLVERR);
    rdchk(ADDR_MIN_DELTA, ALL, 32'h0, RESP_OKAY);
    wr(ADDR_CTRL, 32'h11, RESP_OKAY);
  endtask
  task automatic t_first;
    pkt_go(4'h3, 12'h28, 32'd1000, 12'hA, 32'hF, 32'h1);
    chk({16'h0, u_far.bw_last.base}, 32'h12);
    chk({31'h0, u_far.rep_last.chan_init}, 32'h1);
    chk({31'h0, u_far.rep_last.shared_pdv_initialized}, 32'h1);
    chk(u_far.rep_last.ctx_addr, 32'hABCD_0000);
    chk(u_far.rep_last.local_ts, 32'd1000);
    rdchk(ADDR_CTRL, 32'hFF, 32'h12, RESP_OKAY);
    rdchk(ADDR_SAMPLES, 32'hFFF, 32'h28, RESP_OKAY);
    rdchk(ADDR_REMOTE_TS, ALL, 32'd1000, RESP_OKAY);
    rdchk(ADDR_MAX_DELTA, ALL, 32'h0, RESP_OKAY);
    wr(ADDR_CTRL, 32'h2, RESP_OKAY);
  endtask
  task automatic t_inorder;
    pkt_go(4'h4, 12'h28, 32'd1045, 12'h14, 32'h37, 32'h0);
    rdchk(ADDR_MAX_DELTA, ALL, 32'h5, RESP_OKAY);
    rdchk(ADDR_MIN_DELTA, ALL, 32'h0, RESP_OKAY);
    rdchk(ADDR_REMOTE_TS, ALL, 32'd1040, RESP_OKAY);
    rdchk(ADDR_OCT_COUNT, ALL, 32'd94, RESP_OKAY);
  endtask
  task automatic t_slips;
    wr(ADDR_MAX_USED, 32'hA, RESP_OKAY);
    wr(ADDR_CTRL, 32'hA, RESP_OKAY);
    u_far.rpt_wait = 3;
    pkt_go(4'h5, 12'h28, 32'd1085, 12'h5A, 32'h5D, 32'h1);
    chk({31'h0, u_far.rep_last.overrun}, 32'h1);
    chk({31'h0, u_far.rep_last.underrun}, 32'h0);
    pkt_go(4'h6, 12'h28, 32'd1100, 12'hC8, 32'hD0, 32'h1);
    chk({30'h0, u_far.rep_last.underrun2, u_far.rep_last.underrun}, 32'h3);
    rdchk(ADDR_MIN_DELTA, ALL, 32'hFFFF_FFEC, RESP_OKAY);
    u_far.rpt_wait = 0;
  endtask
  task automatic t_loss;
    wr(ADDR_MAX_USED, 32'hC8, RESP_OKAY);
    wr(ADDR_CTRL, 32'hF, RESP_OKAY);
    pkt_go(4'h8, 12'h28, 32'd1210, 12'h0, 32'h20, 32'h1);
    chk({31'h0, u_far.rep_last.samples_lost_flag}, 32'h1);
    chk(u_far.rep_last.samples_lost, 32'd40);
    chk(u_far.rep_last.remote_ts, 32'd1200);
    chk({31'h0, u_far.rep_last.restart_done}, 32'h1);
    rdchk(ADDR_MIN_DELTA, ALL, 32'hA, RESP_OKAY);
    rdchk(ADDR_MAX_DELTA, ALL, 32'hA, RESP_OKAY);
    rdchk(ADDR_CTRL, 32'h1, 32'h0, RESP_OKAY);
  endtask
  task automatic t_length;
    wr(ADDR_OVR_CH, 32'h0003_0003, RESP_OKAY);
    wr(ADDR_CTRL, 32'hA, RESP_OKAY);
    pkt_go(4'h9, 12'h28, 32'd1300, 12'h0, ALL, 32'h1);
    chk({31'h0, u_far.rep_last.length_not_divisible_error}, 32'h1);
    wr(ADDR_OVR_CH, 32'h0001_0003, RESP_OKAY);
    // Largest code cannot be overfilled with a 12-bit sample count
    for (int s = 0; s < 4; s++) begin
      wr(ADDR_CTRL, 32'hA | (s << 5), RESP_OKAY);
      pkt_go(4'h9, (12'h100 << s) + 12'h1, 32'd1300, 12'h0, ALL, 32'h1);
      chk({31'h0, u_far.rep_last.length_oversize_error}, 32'h1);
    end
    rdchk(ADDR_PKT_COUNT, ALL, 32'd10, RESP_OKAY);
    rdchk(ADDR_OCT_COUNT, ALL, 32'd470, RESP_OKAY);
  endtask
  initial begin
    repeat (20000) @(posedge aclk);
    n_errors++;
    final_report();
  end
  initial begin
    aresetn <= 1'h0;
    s_axi_awaddr <= 12'h0;
    s_axi_araddr <= 12'h0;
    s_axi_wdata <= 32'h0;
    s_axi_awvalid <= 1'h0;
    s_axi_wvalid <= 1'h0;
    s_axi_bready <= 1'h0;
    s_axi_arvalid <= 1'h0;
    s_axi_rready <= 1'h0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'h1;
    t_regs();
    t_first();
    t_inorder();
    t_slips();
    t_loss();
    t_length();
    final_report();
  end
endmodule
bind aal2_voice_rx_dejitter_channel aal2_rx_asserts u_chk (.aclk, .aresetn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .pkt, .pkt_valid, .pkt_ready, .buf_write,
  .buf_write_valid, .report, .report_valid, .report_ready);
`default_nettype wire
